/* rtl/gesture_exit_defines.vh */
/*
 Register offsets, field positions, reset values and codes for the gesture
 exit and FIFO trigger block. Included by the block's single design file.
*/
`ifndef GESTURE_EXIT_DEFINES_VH
`define GESTURE_EXIT_DEFINES_VH

// Wishbone byte offsets
`define ADDR_EXIT_THRESHOLD   4'h0
`define ADDR_EXIT_FIFO_CONFIG 4'h4
`define ADDR_CONTROL          4'h8
`define ADDR_STATUS           4'hC
`define ADDR_IRQ_STATUS       4'h0
`define ADDR_IRQ_MASK         4'h4
`define ADDR_PAGE_CFG         1'b0
`define ADDR_PAGE_IRQ         1'b1

// Configuration fields
`define FIFO_TRIG_HI          7
`define FIFO_TRIG_LO          6
`define EXIT_MASK_HI          5
`define EXIT_MASK_LO          2
`define EXIT_PERS_HI          1
`define EXIT_PERS_LO          0

// Exit mask bit per detector
`define MASK_BIT_EAST         0
`define MASK_BIT_WEST         1
`define MASK_BIT_SOUTH        2
`define MASK_BIT_NORTH        3

// Control register bits
`define CTRL_RUN              0
`define CTRL_FIFO_IRQ_EN      1

// Interrupt status bits
`define IRQ_EXIT              0
`define IRQ_FIFO              1
`define IRQ_WIDTH             2

// Reset values
`define RST_THRESHOLD         8'h00
`define RST_FIFO_CONFIG       8'h00
`define RST_CONTROL           1'b0
`define RST_IRQ               2'h0

// Threshold code meaning "never exit"
`define EXIT_TH_NEVER         8'h00

// FIFO trigger levels per code
`define FIFO_LVL_00           6'h01
`define FIFO_LVL_01           6'h04
`define FIFO_LVL_10           6'h08
`define FIFO_LVL_11           6'h10

// Consecutive gesture-end counts per persistence code
`define PERS_CNT_00           3'h1
`define PERS_CNT_01           3'h2
`define PERS_CNT_10           3'h4
`define PERS_CNT_11           3'h7

`endif

/* rtl/gesture_exit_trigger.v */
/*
 Gesture exit detection and FIFO level trigger, with a classic Wishbone
 register slave and a level interrupt output.
 Assumes one 200 MHz clock, a synchronous active-high reset, and that the
 photodiode data, its valid strobe and the FIFO level come from the gesture
 engine on the same clock.
*/
// Behaviour
// - Compare 8-bit exit threshold against data of every unmasked direction detector.
// - Exit needs the configured persistence count of consecutive ends; code 00 exits on one.
// - Threshold zero: never exit by itself; stay until software clears run flag.
// - FIFO level reaching trigger raises gesture interrupt only when enabled.
// - Trigger code 00,01,10,11 means 1,4,8,16 added datasets.
// - Four-bit exit mask, one per detector; set bit removes its data.
// - Mask bit 0 east, 1 west, 2 south, 3 north.
// - Mask all zeros includes all four detectors.
// - Mask values act bitwise, e.g. 0110 drops west and south.
// - Persistence code 00,01,10,11 exits on 1st,2nd,4th,7th consecutive end.
`timescale 1ns/1ps
`include "gesture_exit_defines.vh"

module gesture_exit_trigger
#(
    parameter DATA_W  = 8,
    parameter LEVEL_W = 6
)
(
    input  wire               clk_i,
    input  wire               rst_i,
    // Wishbone classic slave
    input  wire               cyc_i,
    input  wire               stb_i,
    input  wire               we_i,
    input  wire [4:0]         adr_i,
    input  wire [3:0]         sel_i,
    input  wire [31:0]        dat_i,
    output reg  [31:0]        dat_o,
    output reg                ack_o,
    // Gesture engine side
    input  wire               entry_i,
    input  wire               dataset_valid_i,
    input  wire [DATA_W-1:0]  north_i,
    input  wire [DATA_W-1:0]  south_i,
    input  wire [DATA_W-1:0]  west_i,
    input  wire [DATA_W-1:0]  east_i,
    input  wire [LEVEL_W-1:0] fifo_level_i,
    output reg                gesture_active_o,
    output reg                exit_pulse_o,
    output wire               irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0]           exit_threshold;
reg  [7:0]           exit_fifo_config;
reg                  gesture_run_flag;
reg                  fifo_irq_en;
reg  [`IRQ_WIDTH-1:0] irq_status;
reg  [`IRQ_WIDTH-1:0] irq_mask;
reg  [2:0]           exit_persistence_count;
reg                  fifo_above;

wire [7:0] exit_threshold_value = exit_threshold;
wire [1:0] fifo_level_trigger   = exit_fifo_config[`FIFO_TRIG_HI:`FIFO_TRIG_LO];
wire [3:0] exit_detector_mask   = exit_fifo_config[`EXIT_MASK_HI:`EXIT_MASK_LO];
wire [1:0] exit_persistence_setting = exit_fifo_config[`EXIT_PERS_HI:`EXIT_PERS_LO];

wire bus_req   = cyc_i & stb_i & ~ack_o;
wire bus_write = bus_req & we_i & sel_i[0];
wire page_irq  = adr_i[4];
wire [3:0] reg_off = adr_i[3:0];

////////////////////////////////////////////////////////////////////////////////
// Gesture end evaluation

reg [DATA_W-1:0] dir_data [0:3];
always @*
begin
    dir_data[`MASK_BIT_EAST]  = east_i;
    dir_data[`MASK_BIT_WEST]  = west_i;
    dir_data[`MASK_BIT_SOUTH] = south_i;
    dir_data[`MASK_BIT_NORTH] = north_i;
end

// A masked detector always counts as quiet, so all-masked means always ended
wire [3:0] dir_quiet;
genvar g;
generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_dir
        assign dir_quiet[g] = exit_detector_mask[g] |
                              (dir_data[g] <= exit_threshold_value);
    end
endgenerate

wire gesture_end = &dir_quiet;

reg [2:0] pers_target;
always @*
begin
    case (exit_persistence_setting)
        2'b00:   pers_target = `PERS_CNT_00;
        2'b01:   pers_target = `PERS_CNT_01;
        2'b10:   pers_target = `PERS_CNT_10;
        2'b11:   pers_target = `PERS_CNT_11;
        default: pers_target = `PERS_CNT_00;
    endcase
end

wire never_exit = (exit_threshold_value == `EXIT_TH_NEVER);
wire next_count_hit = ({1'b0, exit_persistence_count} + 4'h1) >= {1'b0, pers_target};
wire exit_now = gesture_active_o & dataset_valid_i & gesture_end &
                ~never_exit & next_count_hit;

////////////////////////////////////////////////////////////////////////////////
// FIFO trigger

reg [LEVEL_W-1:0] fifo_target;
always @*
begin
    case (fifo_level_trigger)
        2'b00:   fifo_target = `FIFO_LVL_00;
        2'b01:   fifo_target = `FIFO_LVL_01;
        2'b10:   fifo_target = `FIFO_LVL_10;
        2'b11:   fifo_target = `FIFO_LVL_11;
        default: fifo_target = `FIFO_LVL_00;
    endcase
end

wire fifo_reach = (fifo_level_i >= fifo_target);
// Edge of reaching, so a level that stays high raises the flag only once
wire fifo_event = fifo_reach & ~fifo_above & fifo_irq_en;

////////////////////////////////////////////////////////////////////////////////
// State and counters

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        gesture_active_o       <= 1'b0;
        exit_persistence_count <= 3'h0;
        exit_pulse_o           <= 1'b0;
        fifo_above             <= 1'b0;
    end
    else
    begin
        exit_pulse_o <= exit_now;
        fifo_above   <= fifo_reach;
        if (!gesture_run_flag)
        begin
            gesture_active_o       <= 1'b0;
            exit_persistence_count <= 3'h0;
        end
        else if (!gesture_active_o)
        begin
            gesture_active_o       <= entry_i;
            exit_persistence_count <= 3'h0;
        end
        else if (exit_now)
        begin
            gesture_active_o       <= 1'b0;
            exit_persistence_count <= 3'h0;
        end
        else if (dataset_valid_i)
        begin
            if (gesture_end && !never_exit)
                exit_persistence_count <= exit_persistence_count + 3'h1;
            else
                exit_persistence_count <= 3'h0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes and interrupt flags

wire [`IRQ_WIDTH-1:0] irq_events;
assign irq_events[`IRQ_EXIT] = exit_now;
assign irq_events[`IRQ_FIFO] = fifo_event;

wire [`IRQ_WIDTH-1:0] irq_clear =
    (bus_write && page_irq && reg_off == `ADDR_IRQ_STATUS) ?
    dat_i[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        exit_threshold   <= `RST_THRESHOLD;
        exit_fifo_config <= `RST_FIFO_CONFIG;
        gesture_run_flag <= `RST_CONTROL;
        fifo_irq_en      <= `RST_CONTROL;
        irq_status       <= `RST_IRQ;
        irq_mask         <= `RST_IRQ;
    end
    else
    begin
        // A new event wins over a clear in the same cycle
        irq_status <= (irq_status & ~irq_clear) | irq_events;
        if (bus_write && !page_irq)
        begin
            case (reg_off)
                `ADDR_EXIT_THRESHOLD:   exit_threshold   <= dat_i[7:0];
                `ADDR_EXIT_FIFO_CONFIG: exit_fifo_config <= dat_i[7:0];
                `ADDR_CONTROL:
                begin
                    gesture_run_flag <= dat_i[`CTRL_RUN];
                    fifo_irq_en      <= dat_i[`CTRL_FIFO_IRQ_EN];
                end
                default: ;
            endcase
        end
        if (bus_write && page_irq && reg_off == `ADDR_IRQ_MASK)
            irq_mask <= dat_i[`IRQ_WIDTH-1:0];
    end
end

assign irq_o = |(irq_status & irq_mask);

////////////////////////////////////////////////////////////////////////////////
// Bus answer: registered ack one cycle after the request, ack for exactly one cycle

reg [31:0] rd_data;
always @*
begin
    rd_data = 32'h0000_0000;
    if (!page_irq)
    begin
        case (reg_off)
            `ADDR_EXIT_THRESHOLD:   rd_data[7:0] = exit_threshold;
            `ADDR_EXIT_FIFO_CONFIG: rd_data[7:0] = exit_fifo_config;
            `ADDR_CONTROL:
            begin
                rd_data[`CTRL_RUN]         = gesture_run_flag;
                rd_data[`CTRL_FIFO_IRQ_EN] = fifo_irq_en;
            end
            `ADDR_STATUS:
                rd_data[4:0] = {exit_persistence_count, fifo_reach, gesture_active_o};
            default: rd_data = 32'h0000_0000;
        endcase
    end
    else
    begin
        case (reg_off)
            `ADDR_IRQ_STATUS: rd_data[`IRQ_WIDTH-1:0] = irq_status;
            `ADDR_IRQ_MASK:   rd_data[`IRQ_WIDTH-1:0] = irq_mask;
            default:          rd_data = 32'h0000_0000;
        endcase
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_o <= 1'b0;
        dat_o <= 32'h0000_0000;
    end
    else
    begin
        ack_o <= bus_req;
        dat_o <= bus_req ? rd_data : 32'h0000_0000;
    end
end

endmodule

/* dv/gesture_engine_model.sv */
/* Far-side gesture engine model: sends one dataset per request.
   Assumes requests change just after a rising clock edge. */
`timescale 1ns/1ps
module gesture_engine_model
(
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [31:0] four_direction_photodiodes_i,
    output logic             valid_o,
    output logic [31:0]      four_direction_photodiodes_o
);
    // Outside a dataset the lines toggle, so stale data is never taken as fresh
    always @(posedge clk_i)
    begin
        valid_o <= go_i;
        four_direction_photodiodes_o  <= go_i ? four_direction_photodiodes_i : ~four_direction_photodiodes_o;
    end
endmodule

/* dv/gesture_exit_trigger_assertions.sv */
/* Port checks for the gesture exit block.
   Bound into the block; one clock, synchronous reset. */
`timescale 1ns/1ps
module gesture_exit_trigger_assertions
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        entry_i,
    input wire logic        dataset_valid_i,
    input wire logic        gesture_active_o,
    input wire logic        exit_pulse_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_acked;
        s_req ##1 ack_o;
    endsequence
    a_ack_answers: assert property (s_req |=> ack_o)
        else $error("no ack");
    a_ack_single: assert property (s_acked |=> !ack_o)
        else $error("long ack");
    a_ack_caused: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("stray ack");
    a_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("stray data");
    a_exit_on_data: assert property (exit_pulse_o |-> $past(dataset_valid_i))
        else $error("exit without data");
    a_exit_leaves: assert property (exit_pulse_o |-> !gesture_active_o && $past(gesture_active_o))
        else $error("bad exit");
    a_exit_single: assert property (exit_pulse_o |=> !exit_pulse_o)
        else $error("long exit");
    a_entry_cause: assert property ($rose(gesture_active_o) |-> $past(entry_i))
        else $error("entry without cause");
endmodule
bind gesture_exit_trigger gesture_exit_trigger_assertions gesture_exit_trigger_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
    .entry_i(entry_i), .dataset_valid_i(dataset_valid_i), .gesture_active_o(gesture_active_o),
    .exit_pulse_o(exit_pulse_o));

/* dv/gesture_exit_trigger_bench.sv */
/* Bench: registers, exit mask, persistence, threshold zero, FIFO interrupt.
   Assumes the engine model and the bound checker. */
`timescale 1ns/1ps
module gesture_exit_trigger_bench;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, en = 0, go = 0;
    logic        ack, act_o, xp, irq, dv;
    logic [4:0]  adr = 5'h00;
    logic [5:0]  lvl = 6'h00;
    logic [15:0] seed = 16'h4520;
    logic [31:0] dat = 32'h0, dat_o, four_direction_photodiodes = 32'h0, nd;
    logic [31:0] q[$];
    logic [4:0]  ra[6] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h14, 5'h18};
    logic [3:0]  mk[7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'hF};
    logic [5:0]  lvs[4] = '{6'h01, 6'h04, 6'h08, 6'h10};
    int          tg[4] = '{1, 2, 4, 7};
    int          checks_done = 0, miscompares = 0, exits = 0;
    always #2.5 clk_i = ~clk_i;
    gesture_engine_model gesture_engine_model_i (.clk_i(clk_i), .go_i(go), .four_direction_photodiodes_i(four_direction_photodiodes),
        .valid_o(dv), .four_direction_photodiodes_o(nd));
    gesture_exit_trigger gesture_exit_trigger_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack), .entry_i(en), .dataset_valid_i(dv), .north_i(nd[31:24]),
        .south_i(nd[23:16]), .west_i(nd[15:8]), .east_i(nd[7:0]), .fifo_level_i(lvl),
        .gesture_active_o(act_o), .exit_pulse_o(xp), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task complete_run;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            complete_run();
        end
        {cyc, stb} <= 2'b00;
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        wb(1'b0, a, 8'h00);
    endtask
    // Read data is compared by this watcher, in request order
    always @(posedge clk_i)
        if (ack === 1'b1 && !we)
            chk(dat_o, q.pop_front());
    // Every exit pulse is counted and compared at the end of the run
    always @(posedge clk_i)
        if (xp === 1'b1)
            exits++;
    task ds(input logic [31:0] v);
        @(posedge clk_i);
        {go, four_direction_photodiodes} <= {1'b1, v};
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic at(ref logic s, input logic e);
        @(negedge clk_i);
        chk(s, {31'h0, e});
    endtask
    task enter;
        @(posedge clk_i);
        en <= 1'b1;
        @(posedge clk_i);
        en <= 1'b0;
    endtask
    task lv(input logic [5:0] v);
        @(posedge clk_i);
        lvl <= v;
        @(negedge clk_i);
    endtask
    function logic [31:0] vec(input logic [3:0] m, input logic [7:0] i, input logic [7:0] x);
        for (int b = 0; b < 4; b++)
            vec[8*b +: 8] = m[b] ? x : i;
    endfunction
    function logic [7:0] quiet;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0] % 8'h0B;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) rd(ra[i], 8'h00);
        wb(1'b1, 5'h00, 8'h0A);
        wb(1'b1, 5'h08, 8'h01);
        foreach (mk[i])
        begin
            wb(1'b1, 5'h04, {2'b00, mk[i], 2'b00});
            enter();
            ds(vec(mk[i], 8'h0B, 8'h00));
            at(act_o, mk[i] != 4'hF);
            ds(vec(mk[i], 8'h0A, 8'hC8));
            at(act_o, 1'b0);
        end
        for (int p = 0; p < 4; p++)
        begin
            wb(1'b1, 5'h04, 8'(p));
            enter();
            repeat (tg[p] - 1) ds(vec(4'h0, quiet(), 8'h00));
            ds(vec(4'h0, 8'h0B, 8'h00));
            repeat (tg[p] - 1) ds(vec(4'h0, quiet(), 8'h00));
            at(act_o, 1'b1);
            ds(vec(4'h0, quiet(), 8'h00));
            at(act_o, 1'b0);
        end
        rd(5'h10, 8'h01);
        at(irq, 1'b0);
        wb(1'b1, 5'h14, 8'h01);
        at(irq, 1'b1);
        wb(1'b1, 5'h10, 8'h01);
        at(irq, 1'b0);
        wb(1'b1, 5'h00, 8'h00);
        enter();
        repeat (8) ds(32'h0);
        at(act_o, 1'b1);
        wb(1'b1, 5'h08, 8'h00);
        at(act_o, 1'b0);
        wb(1'b1, 5'h14, 8'h02);
        for (int p = 0; p < 4; p++)
        begin
            wb(1'b1, 5'h04, {p[1:0], 6'h00});
            wb(1'b1, 5'h08, 8'h02);
            lv(lvs[p] - 6'h01);
            at(irq, 1'b0);
            lv(lvs[p]);
            at(irq, 1'b1);
            wb(1'b1, 5'h10, 8'h02);
            at(irq, 1'b0);
            lv(6'h00);
        end
        wb(1'b1, 5'h08, 8'h00);
        lv(6'h10);
        at(irq, 1'b0);
        chk(exits, 32'd11);
        complete_run();
    end
endmodule
